// file: verilog/acd_pkg.sv
// shared constants and types of the converter correction and dma block
package acd_pkg;
    // register byte offsets
    localparam logic [7:0] CFG_OFF = 8'h00;
    localparam logic [7:0] OFFSET_OFF = 8'h04;
    localparam logic [7:0] GAIN_OFF = 8'h08;
    localparam logic [7:0] DMACTL_OFF = 8'h0C;
    localparam logic [7:0] START_OFF = 8'h10;
    localparam logic [7:0] COUNT_OFF = 8'h14;
    localparam logic [7:0] CUR_OFF = 8'h18;
    localparam logic [7:0] FLAG_OFF = 8'h1C;
    localparam logic [7:0] ANA_OFF = 8'h20;
    localparam logic [7:0] PIN_OFF = 8'h24;
    // configuration fields
    localparam int CFG_EN_BIT = 0;
    localparam int CFG_SLOW_BIT = 2;
    localparam int CFG_NEG_LSB = 3;
    localparam int CFG_POS_LSB = 7;
    localparam int CFG_NBUF_BIT = 11;
    localparam int CFG_PBUF_BIT = 12;
    localparam int CFG_PER_LSB = 13;
    // dma control and flag fields
    localparam int DMA_LOAD_BIT = 0;
    localparam int DMA_WRAP_BIT = 1;
    localparam int DMA_RST_BIT = 4;
    localparam int FLG_SAT = 0;
    localparam int FLG_HALF = 1;
    localparam int FLG_FULL = 2;
    localparam int FLG_OVF = 3;
    // reset values and limits
    localparam logic [15:0] CFG_RST = 16'h0000;
    localparam logic [15:0] OFFSET_RST = 16'h0000;
    localparam logic [15:0] GAIN_RST = 16'h8000;
    localparam logic [15:0] SAT_MAX = 16'h7FFF;
    localparam logic [15:0] SAT_MIN = 16'h8000;
    // timing
    localparam int PCLK_PERIOD_NS = 40;
    localparam int PCLK_MHZ = 25;
    localparam int FAST_MHZ = 6;
    localparam int SLOW_MHZ = 1;
    localparam int STARTUP_NS = 21000;
    localparam int STARTUP_CYC =
        (STARTUP_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
    localparam int BASE_CLOCKS = 32;
    localparam int MIN_BITS = 5;

    typedef enum logic [1:0] {
        DMA_IDLE = 2'b00,
        DMA_RUN = 2'b01,
        DMA_FULL = 2'b10
    } acd_dma_state_type;

    typedef enum logic [1:0] {
        SMP_OFF = 2'b00,
        SMP_WARM = 2'b01,
        SMP_RUN = 2'b10
    } acd_smp_state_type;

    // one-hot source enable: 0..5 pins, 8..11 internal at bits 6..9
    function automatic logic [9:0] mux_decode(input logic [3:0] code);
        logic [9:0] hot;
        hot = 10'h000;
        if (code <= 4'h5) begin
            hot[code] = 1'b1;
        end else if (code >= 4'h8 && code <= 4'hB) begin
            hot[code - 4'h2] = 1'b1;
        end
        return hot;
    endfunction : mux_decode
endpackage : acd_pkg

// file: verilog/acd_correct.sv
// offset, gain, saturation and halving of one raw result
`timescale 1ns/1ps
module acd_correct (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // raw result
    input wire logic in_valid,
    input wire logic [15:0] in_raw,
    input wire logic [15:0] offset,
    input wire logic [15:0] gain,
    // corrected result
    output logic out_valid,
    output logic [15:0] out_data,
    output logic out_sat
);
    logic signed [16:0] sum;
    logic signed [33:0] scaled;
    logic signed [15:0] clamped;
    logic sat;

    always_comb begin
        // wide sum so the offset never wraps before the gain stage
        sum = 17'($signed(in_raw)) + 17'($signed(offset));
        // gain is 1.15 unsigned: multiply, drop 15 fraction bits
        scaled = (34'(sum) * 34'($signed({1'b0, gain}))) >>> 15;
        sat = 1'b1;
        if (scaled > 34'($signed(acd_pkg::SAT_MAX))) begin
            clamped = $signed(acd_pkg::SAT_MAX);
        end else if (scaled < 34'($signed(acd_pkg::SAT_MIN))) begin
            clamped = $signed(acd_pkg::SAT_MIN);
        end else begin
            clamped = scaled[15:0];
            sat = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid <= 1'b0;
            out_data <= 16'h0000;
            out_sat <= 1'b0;
        end else begin
            out_valid <= in_valid;
            out_data <= 16'(clamped >>> 1);
            out_sat <= in_valid & sat;
        end
    end

    sat_clamp_a: assert property (@(posedge pclk) disable iff (!presetn)
        out_sat |-> (out_data == 16'h3FFF || out_data == 16'hC000))
        else $error("saturated sample not at halved limit");
endmodule : acd_correct

// file: verilog/acd_sampler.sv
// sampling clock, start-up delay and sample period timing
`timescale 1ns/1ps
module acd_sampler (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic enable,
    input wire logic slow_sel,
    input wire logic [2:0] period,
    input wire logic restart,
    // status
    output logic sample_done,
    output logic modulator_run
);
    acd_pkg::acd_smp_state_type state_q;
    logic [4:0] acc_q;
    logic [5:0] acc_sum;
    logic tick;
    logic [9:0] warm_q;
    logic [12:0] cnt_q;
    logic [12:0] last_cnt;
    logic discard_q;

    // fractional divider from pclk, so timing follows no cpu clock source
    always_comb begin
        acc_sum = {1'b0, acc_q} + (slow_sel ? 6'(acd_pkg::SLOW_MHZ)
                                            : 6'(acd_pkg::FAST_MHZ));
        tick = acc_sum >= 6'(acd_pkg::PCLK_MHZ);
        last_cnt = (13'(acd_pkg::BASE_CLOCKS) << period) - 13'h0001;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= 5'h00;
        end else begin
            acc_q <= tick ? 5'(acc_sum - 6'(acd_pkg::PCLK_MHZ)) : acc_sum[4:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= acd_pkg::SMP_OFF;
            warm_q <= 10'h000;
            cnt_q <= 13'h0000;
            discard_q <= 1'b1;
            sample_done <= 1'b0;
        end else begin
            sample_done <= 1'b0;
            case (state_q)
                acd_pkg::SMP_OFF: begin
                    warm_q <= 10'h000;
                    if (enable) begin
                        state_q <= acd_pkg::SMP_WARM;
                    end
                end
                acd_pkg::SMP_WARM: begin
                    warm_q <= warm_q + 10'h001;
                    cnt_q <= 13'h0000;
                    discard_q <= 1'b1;
                    if (!enable) begin
                        state_q <= acd_pkg::SMP_OFF;
                    end else if (warm_q == 10'(acd_pkg::STARTUP_CYC - 1)) begin
                        state_q <= acd_pkg::SMP_RUN;
                    end
                end
                acd_pkg::SMP_RUN: begin
                    if (!enable) begin
                        state_q <= acd_pkg::SMP_OFF;
                    end else if (restart) begin
                        cnt_q <= 13'h0000;
                        discard_q <= 1'b1;
                    end else if (tick) begin
                        if (cnt_q == last_cnt) begin
                            cnt_q <= 13'h0000;
                            discard_q <= 1'b0;
                            sample_done <= !discard_q;
                        end else begin
                            cnt_q <= cnt_q + 13'h0001;
                        end
                    end
                end
                default: state_q <= acd_pkg::SMP_OFF;
            endcase
        end
    end

    assign modulator_run = state_q == acd_pkg::SMP_RUN;
endmodule : acd_sampler

// file: verilog/acd_top.sv
// register file, result path and dma channel of the converter back-end
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - raw 16-bit result gets the signed offset added first
// - gain product clamps to 0x7FFF or 0x8000 and raises saturation flag
// - corrected value is halved to give the delivered sample
// - gain is unsigned with one integer and fifteen fraction bits
// - reset leaves offset zero and gain 0x8000, unity gain
// - dma writes corrected samples, never raw ones
// - software resets then loads the dma; load starts at buffer start
// - wrap select 0 means linear, 1 means circular
// - linear mode stops after the count and sets full flag
// - sample arriving while linear buffer is full sets overflow
// - wrap mode returns to start and keeps writing
// - half flag after lower half, full flag after upper half
// - current dma write address is readable
// - select codes 0-5 pins, 8-11 internal, rest unconnected
// - each input has its own quarter-gain buffer enable
// - clear select gives 6 MHz sampling, set gives 1 MHz
// - period k gives 32 times two to the k clocks
// - sample is 16 bits with significant bits left-aligned
// - significant bits are five plus the period code
// - sample timing does not depend on cpu clock source
// - analog-mode pin loses digital use and reads as one
// - enable from off waits 21 us before converting
// - first conversion after enable or change is discarded
// - writing one clears a flag, zero leaves it
module acd_top #(
    parameter int AW = 16,
    parameter int NPIN = 6
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // modulator and clock controller
    input wire logic [15:0] raw_data,
    input wire logic clk_source_switch,
    output logic modulator_run,
    // analog front-end controls
    output logic [9:0] pos_source_en,
    output logic [9:0] neg_source_en,
    output logic positive_buffer_enable,
    output logic negative_buffer_enable,
    output logic slow_sample_clock_select,
    // ram write port
    output logic ram_wr_en,
    output logic [AW-1:0] ram_addr,
    output logic [15:0] ram_wdata,
    // general-purpose pins
    input wire logic [NPIN-1:0] gpio_pin_in,
    output logic [NPIN-1:0] gpio_digital_en
);
    localparam logic [AW-1:0] ONE = AW'(1);
    localparam logic [AW-1:0] TWO = AW'(2);

    logic [15:0] cfg_q, offset_q, gain_q;
    logic wrap_q;
    logic [AW-1:0] start_q, count_q, cur_q, done_q;
    logic [3:0] flags_q, flag_set;
    logic [NPIN-1:0] ana_q, sync1_q, sync2_q, sync3_q, pin_q;
    acd_pkg::acd_dma_state_type dma_q;
    logic wr_acc, rd_setup, mapped;
    logic [31:0] rd_val;
    logic dma_load, dma_rst;
    logic smp_done, corr_valid, corr_sat;
    logic [15:0] corr_data, raw_masked;
    logic [AW-1:0] done_next;
    logic at_half, at_end;

    ////////////////////////////////////////////////////////////////////////
    // apb decode: zero wait states, read data captured in setup
    always_comb begin
        wr_acc = psel & penable & pwrite;
        rd_setup = psel & ~penable & ~pwrite;
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        case (paddr)
            acd_pkg::CFG_OFF: rd_val = 32'(cfg_q);
            acd_pkg::OFFSET_OFF: rd_val = 32'(offset_q);
            acd_pkg::GAIN_OFF: rd_val = 32'(gain_q);
            acd_pkg::DMACTL_OFF: rd_val = 32'({dma_q, wrap_q, 1'b0});
            acd_pkg::START_OFF: rd_val = 32'(start_q);
            acd_pkg::COUNT_OFF: rd_val = 32'(count_q);
            acd_pkg::CUR_OFF: rd_val = 32'(cur_q);
            acd_pkg::FLAG_OFF: rd_val = 32'(flags_q);
            acd_pkg::ANA_OFF: rd_val = 32'(ana_q);
            acd_pkg::PIN_OFF: rd_val = 32'(pin_q | ana_q);
            default: mapped = 1'b0;
        endcase
    end

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= rd_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= acd_pkg::CFG_RST;
            offset_q <= acd_pkg::OFFSET_RST;
            gain_q <= acd_pkg::GAIN_RST;
            wrap_q <= 1'b0;
            start_q <= '0;
            count_q <= '0;
            ana_q <= '0;
        end else if (wr_acc) begin
            case (paddr)
                acd_pkg::CFG_OFF: cfg_q <= pwdata[15:0];
                acd_pkg::OFFSET_OFF: offset_q <= pwdata[15:0];
                acd_pkg::GAIN_OFF: gain_q <= pwdata[15:0];
                acd_pkg::DMACTL_OFF: wrap_q <= pwdata[acd_pkg::DMA_WRAP_BIT];
                acd_pkg::START_OFF: start_q <= pwdata[AW-1:0];
                acd_pkg::COUNT_OFF: count_q <= pwdata[AW-1:0];
                acd_pkg::ANA_OFF: ana_q <= pwdata[NPIN-1:0];
                default: ;
            endcase
        end
    end

    // analog controls come from flip-flops so the front-end sees no glitch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_source_en <= 10'h000;
            neg_source_en <= 10'h000;
            positive_buffer_enable <= 1'b0;
            negative_buffer_enable <= 1'b0;
            slow_sample_clock_select <= 1'b0;
        end else begin
            pos_source_en <= acd_pkg::mux_decode(
                cfg_q[acd_pkg::CFG_POS_LSB +: 4]);
            neg_source_en <= acd_pkg::mux_decode(
                cfg_q[acd_pkg::CFG_NEG_LSB +: 4]);
            positive_buffer_enable <= cfg_q[acd_pkg::CFG_PBUF_BIT];
            negative_buffer_enable <= cfg_q[acd_pkg::CFG_NBUF_BIT];
            slow_sample_clock_select <= cfg_q[acd_pkg::CFG_SLOW_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins: three stages, a change counts once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            pin_q <= '0;
        end else begin
            sync1_q <= gpio_pin_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            for (int i = 0; i < NPIN; i++) begin
                if (sync2_q[i] == sync3_q[i]) begin
                    pin_q[i] <= sync3_q[i];
                end
            end
        end
    end

    assign gpio_digital_en = ~ana_q;

    ////////////////////////////////////////////////////////////////////////
    // sampling and correction
    acd_sampler u_sampler (
        .pclk(pclk),
        .presetn(presetn),
        .enable(cfg_q[acd_pkg::CFG_EN_BIT]),
        .slow_sel(cfg_q[acd_pkg::CFG_SLOW_BIT]),
        .period(cfg_q[acd_pkg::CFG_PER_LSB +: 3]),
        .restart((wr_acc && paddr == acd_pkg::CFG_OFF)
                 | clk_source_switch),
        .sample_done(smp_done),
        .modulator_run(modulator_run)
    );

    // keep only 5+k top bits; lower bits are noise at short periods
    assign raw_masked = raw_data & (16'hFFFF << (4'd11 -
        4'(cfg_q[acd_pkg::CFG_PER_LSB +: 3])));

    acd_correct u_correct (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(smp_done),
        .in_raw(raw_masked),
        .offset(offset_q),
        .gain(gain_q),
        .out_valid(corr_valid),
        .out_data(corr_data),
        .out_sat(corr_sat)
    );

    ////////////////////////////////////////////////////////////////////////
    // dma channel
    always_comb begin
        dma_load = wr_acc && paddr == acd_pkg::DMACTL_OFF
                   && pwdata[acd_pkg::DMA_LOAD_BIT];
        dma_rst = wr_acc && paddr == acd_pkg::DMACTL_OFF
                  && pwdata[acd_pkg::DMA_RST_BIT];
        done_next = done_q + ONE;
        at_half = (count_q >> 1) != '0 && done_next == (count_q >> 1);
        at_end = done_next == count_q;
    end

    // reset beats load when both are written together
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_q <= acd_pkg::DMA_IDLE;
            cur_q <= '0;
            done_q <= '0;
        end else if (dma_rst) begin
            dma_q <= acd_pkg::DMA_IDLE;
            done_q <= '0;
        end else if (dma_load) begin
            dma_q <= acd_pkg::DMA_RUN;
            cur_q <= start_q;
            done_q <= '0;
        end else if (corr_valid && dma_q == acd_pkg::DMA_RUN) begin
            if (at_end && wrap_q) begin
                cur_q <= start_q;
                done_q <= '0;
            end else if (at_end) begin
                dma_q <= acd_pkg::DMA_FULL;
                cur_q <= cur_q + TWO;
                done_q <= done_next;
            end else begin
                cur_q <= cur_q + TWO;
                done_q <= done_next;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_wr_en <= 1'b0;
            ram_addr <= '0;
            ram_wdata <= 16'h0000;
        end else begin
            ram_wr_en <= corr_valid && dma_q == acd_pkg::DMA_RUN && !dma_rst;
            ram_addr <= {cur_q[AW-1:1], 1'b0};
            ram_wdata <= corr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flags: a set in the same cycle as a clear wins
    always_comb begin
        flag_set = 4'h0;
        flag_set[acd_pkg::FLG_SAT] = corr_sat;
        flag_set[acd_pkg::FLG_HALF] = corr_valid
            && dma_q == acd_pkg::DMA_RUN && at_half;
        flag_set[acd_pkg::FLG_FULL] = corr_valid
            && dma_q == acd_pkg::DMA_RUN && at_end;
        flag_set[acd_pkg::FLG_OVF] = corr_valid
            && dma_q == acd_pkg::DMA_FULL;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= 4'h0;
        end else if (wr_acc && paddr == acd_pkg::FLAG_OFF) begin
            flags_q <= (flags_q & ~pwdata[3:0]) | flag_set;
        end else begin
            flags_q <= flags_q | flag_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    reset_gain_a: assert property ($rose(presetn) |->
        gain_q == acd_pkg::GAIN_RST && offset_q == 16'h0000)
        else $error("gain or offset wrong after reset");
    ram_data_a: assert property (ram_wr_en |->
        ram_wdata == $past(corr_data))
        else $error("dma wrote something other than corrected data");
    load_start_a: assert property (dma_load && !dma_rst |=>
        cur_q == $past(start_q) && dma_q == acd_pkg::DMA_RUN)
        else $error("load did not point dma at buffer start");
    linear_stop_a: assert property (corr_valid && dma_q == acd_pkg::DMA_RUN
        && at_end && !wrap_q && !dma_rst && !dma_load |=>
        dma_q == acd_pkg::DMA_FULL ##1 !ram_wr_en)
        else $error("linear dma did not stop at end");
    overflow_set_a: assert property (corr_valid && dma_q == acd_pkg::DMA_FULL
        |=> flags_q[acd_pkg::FLG_OVF])
        else $error("overflow flag missed");
    wrap_return_a: assert property (corr_valid && dma_q == acd_pkg::DMA_RUN
        && at_end && wrap_q && !dma_rst && !dma_load |=>
        cur_q == start_q ##1 ram_addr == {start_q[AW-1:1], 1'b0})
        else $error("wrap did not return to start");
    half_flag_a: assert property (flag_set[acd_pkg::FLG_HALF] |=>
        flags_q[acd_pkg::FLG_HALF])
        else $error("half flag missed");
    addr_step_a: assert property (corr_valid && dma_q == acd_pkg::DMA_RUN
        && !at_end && !dma_rst && !dma_load |=>
        cur_q == $past(cur_q) + TWO)
        else $error("address did not step by two");
    flag_clear_a: assert property (wr_acc && paddr == acd_pkg::FLAG_OFF
        && pwdata[acd_pkg::FLG_SAT] && !corr_sat |=>
        !flags_q[acd_pkg::FLG_SAT])
        else $error("write one did not clear flag");
    pin_read_a: assert property (ana_q[0] && rd_setup
        && paddr == acd_pkg::PIN_OFF |=> prdata[0])
        else $error("analog pin did not read as one");
    sat_flag_a: assert property (corr_sat |=>
        flags_q[acd_pkg::FLG_SAT])
        else $error("saturation flag missed");
    idle_drop_a: assert property (corr_valid
        && dma_q == acd_pkg::DMA_IDLE |=> !ram_wr_en)
        else $error("idle dma wrote a sample");
    source_hot_a: assert property ($onehot0(pos_source_en)
        && $onehot0(neg_source_en))
        else $error("more than one input source enabled");
    run_stop_a: assert property (!cfg_q[acd_pkg::CFG_EN_BIT] |=>
        !modulator_run)
        else $error("converter ran while disabled");

    wrap_c: cover property (corr_valid && at_end && wrap_q
        && dma_q == acd_pkg::DMA_RUN);
    overflow_c: cover property (flag_set[acd_pkg::FLG_OVF]);
    saturate_c: cover property (corr_sat);
    linear_full_c: cover property (dma_q == acd_pkg::DMA_FULL);
    half_c: cover property (flag_set[acd_pkg::FLG_HALF]);
endmodule : acd_top

// file: verif/acd_ram_model.sv
// behavioural system ram behind the dma write port
`timescale 1ns/1ps
module acd_ram_model (
    // clock and write port
    input wire logic pclk,
    input wire logic wr_en,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata
);
    // sparse store keyed by byte address, one halfword per slot
    logic [15:0] mem [logic [15:0]];
    always @(posedge pclk) begin
        if (wr_en === 1'b1) begin
            mem[addr] = wdata;
        end
    end
endmodule : acd_ram_model

// file: verif/acd_top_tb.sv
// self-checking bench of the converter correction and dma block
`timescale 1ns/1ps
module acd_top_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ram_wr_en;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] raw_data, ram_addr, ram_wdata, off, gn;
    logic [16:0] c;
    logic [9:0] pos_en, neg_en;
    logic [5:0] gpio_in, den;
    logic css, mrun, pbuf, nbuf, slow;
    logic err;
    logic [31:0] exp_q[$];
    int n_fail = 0;
    int tests_run = 0;
    ////////////////////////////////////////////////////////////////////////
    acd_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .raw_data(raw_data), .clk_source_switch(css), .modulator_run(mrun),
        .pos_source_en(pos_en), .neg_source_en(neg_en),
        .positive_buffer_enable(pbuf), .negative_buffer_enable(nbuf),
        .slow_sample_clock_select(slow), .ram_wr_en(ram_wr_en),
        .ram_addr(ram_addr), .ram_wdata(ram_wdata),
        .gpio_pin_in(gpio_in), .gpio_digital_en(den));
    acd_ram_model ram (.pclk(pclk), .wr_en(ram_wr_en), .addr(ram_addr),
        .wdata(ram_wdata));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int k = 0; k < 50; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (pready !== 1'b1) begin
            chk("apb timeout", 32'h0, 32'h1);
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_q();
        for (int k = 0; k < 3000 && exp_q.size() > 0; k++) @(posedge pclk);
        if (exp_q.size() != 0) begin
            chk("write timeout", 32'h0, 32'h1);
            finish_test();
        end
    endtask : wait_q
    // expected sample: {saturated, delivered value}
    function automatic logic [16:0] corr(input logic [15:0] r, o, g);
        logic signed [16:0] s;
        logic signed [33:0] p;
        s = $signed({r[15], r}) + $signed({o[15], o});
        p = (s * $signed({1'b0, g})) >>> 15;
        if (p > 34'sh7fff) return {1'b1, 16'h3fff};
        if (p < -34'sh8000) return {1'b1, 16'hc000};
        return {1'b0, p[16:1]};
    endfunction : corr
    // result watcher: every dma write must match the oldest note
    always @(posedge pclk) begin
        if (ram_wr_en === 1'b1) begin
            if (exp_q.size() == 0) chk("extra write", 32'h0, 32'h1);
            else chk("ram write", exp_q.pop_front(), {ram_addr, ram_wdata});
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, paddr, pwdata, raw_data, css} = '0;
        presetn = 1'b0;
        void'($urandom(32'hde43_6b1e));
        gpio_in = 6'($urandom);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, acd_pkg::GAIN_OFF, 32'h0);
        chk("gain reset", 32'h0000_8000, rd);
        apb(1'b0, acd_pkg::OFFSET_OFF, 32'h0);
        chk("offset reset", 32'h0000_0000, rd);
        apb(1'b0, 8'h3C, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        $display("test registers done");
        off = 16'($urandom_range(0, 16'h0fff)) - 16'h0800;
        gn = 16'h4000 + 16'($urandom_range(0, 16'h3fff));
        raw_data <= 16'($urandom);
        apb(1'b1, acd_pkg::OFFSET_OFF, {16'h0, off});
        apb(1'b1, acd_pkg::GAIN_OFF, {16'h0, gn});
        apb(1'b1, acd_pkg::DMACTL_OFF, 32'h10);
        apb(1'b1, acd_pkg::START_OFF, 32'h100);
        apb(1'b1, acd_pkg::COUNT_OFF, 32'h4);
        apb(1'b1, acd_pkg::DMACTL_OFF, 32'h1);
        c = corr(raw_data & 16'hf800, off, gn);
        for (int i = 0; i < 4; i++) exp_q.push_back({16'h100 + 16'(2 * i), c[15:0]});
        apb(1'b1, acd_pkg::CFG_OFF, 32'h49);
        repeat (2) @(posedge pclk);
        chk("pos source", 32'h001, {22'h0, pos_en});
        chk("neg source", 32'h080, {22'h0, neg_en});
        chk("warm up", 32'h0, {31'h0, mrun});
        wait_q();
        // room for one more sample period so the overflow can show
        repeat (300) @(posedge pclk);
        apb(1'b0, acd_pkg::FLAG_OFF, 32'h0);
        chk("linear flags", {28'h0, 3'b111, c[16]}, rd);
        apb(1'b0, acd_pkg::CUR_OFF, 32'h0);
        chk("current addr", 32'h108, rd);
        chk("running", 32'h1, {31'h0, mrun});
        chk("ram content", {16'h0, c[15:0]}, {16'h0, ram.mem[16'h106]});
        $display("test linear done");
        apb(1'b1, acd_pkg::DMACTL_OFF, 32'h10);
        apb(1'b1, acd_pkg::FLAG_OFF, 32'hF);
        apb(1'b0, acd_pkg::FLAG_OFF, 32'h0);
        chk("flags cleared", 32'h0, rd);
        raw_data <= 16'h7800;
        apb(1'b1, acd_pkg::OFFSET_OFF, 32'h7000);
        apb(1'b1, acd_pkg::GAIN_OFF, 32'hffff);
        apb(1'b1, acd_pkg::COUNT_OFF, 32'h2);
        css <= 1'b1;
        @(posedge pclk);
        css <= 1'b0;
        apb(1'b1, acd_pkg::DMACTL_OFF, 32'h3);
        exp_q.push_back({16'h100, 16'h3fff});
        exp_q.push_back({16'h102, 16'h3fff});
        exp_q.push_back({16'h100, 16'h3fff});
        wait_q();
        apb(1'b1, acd_pkg::DMACTL_OFF, 32'h10);
        apb(1'b0, acd_pkg::FLAG_OFF, 32'h0);
        chk("wrap flags", 32'h0000_0007, rd);
        $display("test wrap done");
        apb(1'b1, acd_pkg::ANA_OFF, 32'h3);
        apb(1'b0, acd_pkg::PIN_OFF, 32'h0);
        chk("pin read", {26'h0, gpio_in | 6'h3}, rd);
        chk("digital en", 32'h3c, {26'h0, den});
        apb(1'b1, acd_pkg::CFG_OFF, 32'h1DC5);
        repeat (2) @(posedge pclk);
        chk("buffers clock", 32'h7, {29'h0, pbuf, nbuf, slow});
        chk("pos source", 32'h200, {22'h0, pos_en});
        chk("neg source", 32'h040, {22'h0, neg_en});
        $display("test pins done");
        finish_test();
    end
endmodule : acd_top_tb
